/* include/amc_pkg.sv */
// Package: constants and types for the converter mode control register bank
package amc_pkg;
   // Register addresses
   localparam logic [6:0] AMC_ADDR_RESET  = 7'h00;
   localparam logic [6:0] AMC_ADDR_PWR    = 7'h01;
   localparam logic [6:0] AMC_ADDR_TIMING = 7'h02;
   localparam logic [6:0] AMC_ADDR_OUTDRV = 7'h03;
   localparam logic [6:0] AMC_ADDR_FORMAT = 7'h04;
   // Reset value of every mode register
   localparam logic [7:0] AMC_REG_RESET   = 8'h00;
   // Field positions
   localparam int AMC_RESET_BIT   = 7;
   localparam int AMC_FRAME_BITS  = 16;
   localparam int AMC_OUTPUT_CLOCK_INVERT_BIT  = 3;
   localparam int AMC_TERM_BIT    = 3;
   localparam int AMC_OUTPUT_DISABLE_BIT  = 2;
   localparam int AMC_ABP_BIT     = 2;
   localparam int AMC_OUTPUT_RANDOMIZER_ON_BIT    = 1;
   localparam int AMC_TWOS_BIT    = 0;
   localparam int AMC_DCS_BIT     = 0;
   // Test pattern codes
   localparam logic [2:0] AMC_TP_OFF    = 3'h0;
   localparam logic [2:0] AMC_TP_ZERO   = 3'h1;
   localparam logic [2:0] AMC_TP_ONE    = 3'h3;
   localparam logic [2:0] AMC_TP_CHECK  = 3'h5;
   localparam logic [2:0] AMC_TP_ALT    = 3'h7;
   localparam logic [12:0] AMC_CHECK_A  = 13'h1555;
   localparam logic [12:0] AMC_CHECK_B  = 13'h0AAA;

   // Power-down states
   typedef enum logic [1:0] {
      AMC_PD_RUN   = 2'b00,
      AMC_PD_NAP2  = 2'b01,
      AMC_PD_NAPB  = 2'b10,
      AMC_PD_SLEEP = 2'b11
   } amc_pd_t;

   // Output formats
   typedef enum logic [1:0] {
      AMC_FMT_CMOS   = 2'b00,
      AMC_FMT_LVDS   = 2'b01,
      AMC_FMT_DDRCMOS = 2'b10,
      AMC_FMT_UNUSED = 2'b11
   } amc_fmt_t;

   // Decoded controls driven to the analog core
   typedef struct packed {
      logic        ch1_nap;
      logic        ch2_nap;
      logic        sleep;
      logic        output_clock_invert;
      logic [1:0]  output_clock_phase_delay;
      logic        duty_cycle_stabilizer_on;
      logic [2:0]  lvds_drive_current_select;
      logic        internal_termination_on;
      logic        lvds_double_current;
      logic        output_disable;
      logic [1:0]  output_format_select;
      logic        alternate_bit_polarity;
      logic        output_randomizer_on;
      logic        twos_complement_select;
      logic [2:0]  test_pattern_select;
   } amc_ctrl_t;

   // Serial frame handed from the link domain
   typedef struct packed {
      logic       rd;
      logic [6:0] addr;
      logic [7:0] data;
   } amc_frame_t;
endpackage

/* rtl/amc_regs.sv */
// Mode control register bank with its four-wire serial port
`timescale 1ns/1ps
// What this block does
// - Power-down bits 1-0: run, channel 2 nap, both nap, full sleep.
// - Unused upper bits of each mode register have no effect.
// - Timing bit 3 inverts the output clock when set.
// - Timing bits 2-1 delay output clock by 0, 1/8, 1/4, 3/8 period.
// - Timing bit 0 turns the duty cycle stabilizer on.
// - Output bits 6-4 select LVDS drive current; code 011 unused.
// - Output bit 3 enables termination and doubles drive current.
// - Output bit 2 disables all digital outputs to high impedance.
// - Output bits 1-0 select full-rate CMOS, DDR LVDS, DDR CMOS.
// - Format bits 5-3 choose test pattern: normal, all low, all high.
// - Pattern 101 alternates overrange and data between checkerboard words.
// - Pattern 111 alternates overrange and data between all zeros and ones.
// - Format bit 2 enables alternate bit polarity and forces offset binary.
// - Format bit 1 turns the output randomizer on.
// - Format bit 0 selects two's complement, else offset binary.
// - Frame: chip select low, R/W, 7 address, 8 data, first 16 edges.
// - Read returns register on serial out, leaves register unchanged.
// - Software reset clears every mode register to zero.
module amc_regs
   import amc_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        serial_clk,
   input  wire logic        chip_select_n,
   input  wire logic        serial_in,
   output logic             serial_out_o,
   output logic             serial_out_oe_n,
   input  wire logic [12:0] sample_data,
   output amc_ctrl_t        ctrl,
   output logic [12:0]      pattern_word,
   output logic             pattern_active,
   output logic             outputs_hiz
);

   // ****************************************************************
   // Link domain: serial shift and readback
   // ****************************************************************
   logic [4:0]  bit_count;
   logic [15:0] shift_in;
   logic [7:0]  shift_out;
   logic        frame_toggle;
   logic [7:0]  read_word;

   // Register snapshot for readback, settled long before the data phase
   logic [7:0] reg_pwr;
   logic [7:0] reg_timing;
   logic [7:0] reg_outdrv;
   logic [7:0] reg_format;

   function automatic logic [7:0] read_mux(input logic [6:0] a,
                                           input logic [31:0] regs);
      case (a)
         AMC_ADDR_PWR:    read_mux = regs[7:0];
         AMC_ADDR_TIMING: read_mux = regs[15:8];
         AMC_ADDR_OUTDRV: read_mux = regs[23:16];
         AMC_ADDR_FORMAT: read_mux = regs[31:24];
         default:         read_mux = 8'h00;
      endcase
   endfunction

   // Addressed register for readback; registers are quiet during a read frame
   assign read_word = read_mux(shift_in[6:0],
                               {reg_format, reg_outdrv, reg_timing, reg_pwr});

   // Bit counter and input shift; the count clears while chip select is high.
   // Serial clock only runs inside frames, so chip select is async-cleared.
   // frame capture
   always_ff @(posedge serial_clk or posedge chip_select_n) begin
      if (chip_select_n) begin
         bit_count <= 5'd0;
      end else if (bit_count != 5'(AMC_FRAME_BITS)) begin
         bit_count <= bit_count + 5'd1;
         shift_in  <= {shift_in[14:0], serial_in};
      end
   end

   // Toggle marks a complete 16-bit frame for the register domain
   always_ff @(posedge serial_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_toggle <= 1'b0;
      end else if (!chip_select_n && bit_count == 5'(AMC_FRAME_BITS - 1)) begin
         frame_toggle <= ~frame_toggle;
      end
   end

   // Readback: load on the falling edge after the last address bit, shift out on falling edges.
   // Enable stays in the link domain: a ref_clk stage would miss the half bit.
   // Open drain: enable low pulls the line low for a zero bit
   // readback path
   always_ff @(negedge serial_clk or posedge chip_select_n) begin
      if (chip_select_n) begin
         serial_out_oe_n <= 1'b1;
         shift_out       <= 8'h00;
      end else if (bit_count == 5'd8 && shift_in[7]) begin
         serial_out_oe_n <= read_word[7];
         shift_out       <= read_word;
      end else if (bit_count > 5'd8 && bit_count < 5'(AMC_FRAME_BITS)) begin
         serial_out_oe_n <= shift_out[6];
         shift_out       <= {shift_out[6:0], 1'b0};
      end else if (bit_count == 5'(AMC_FRAME_BITS)) begin
         serial_out_oe_n <= 1'b1;
      end
   end

   // Pulled level of the open-drain pin is always low
   always_ff @(posedge ref_clk) begin
      serial_out_o <= 1'b0;
   end

   // ****************************************************************
   // Register domain: frame crossing
   // ****************************************************************
   logic [2:0] tog_sync;
   logic       frame_done;
   amc_frame_t frame;

   // Two-flop synchroniser plus edge stage for the frame toggle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tog_sync <= 3'b000;
      end else begin
         tog_sync <= {tog_sync[1:0], frame_toggle};
      end
   end
   assign frame_done = tog_sync[2] ^ tog_sync[1];
   // Shift register is quiet after bit 16 until the next frame starts
   assign frame      = amc_frame_t'(shift_in);

   // ****************************************************************
   // Mode registers
   // ****************************************************************
   logic soft_reset;
   assign soft_reset = frame_done && !frame.rd && frame.addr == AMC_ADDR_RESET
                       && frame.data[AMC_RESET_BIT];

   // Register writes; reads leave registers untouched
   // software reset clear
   always_ff @(posedge ref_clk) begin
      if (!rst_n || soft_reset) begin
         reg_pwr    <= AMC_REG_RESET;
         reg_timing <= AMC_REG_RESET;
         reg_outdrv <= AMC_REG_RESET;
         reg_format <= AMC_REG_RESET;
      end else if (frame_done && !frame.rd) begin
         case (frame.addr)
            AMC_ADDR_PWR:    reg_pwr    <= frame.data;
            AMC_ADDR_TIMING: reg_timing <= frame.data;
            AMC_ADDR_OUTDRV: reg_outdrv <= frame.data;
            AMC_ADDR_FORMAT: reg_format <= frame.data;
            default:         ;
         endcase
      end
   end

   // ****************************************************************
   // Decoded controls
   // ****************************************************************
   amc_ctrl_t next_ctrl;
   amc_pd_t   pd_mode;
   assign pd_mode = amc_pd_t'(reg_pwr[1:0]);

   // Upper bits are never looked at, so they cannot steer anything
   // ignore upper bits
   always_comb begin
      next_ctrl = '0;
      case (pd_mode)
         AMC_PD_RUN:   next_ctrl.sleep = 1'b0;
         AMC_PD_NAP2:  next_ctrl.ch2_nap = 1'b1;
         AMC_PD_NAPB: begin
            next_ctrl.ch1_nap = 1'b1;
            next_ctrl.ch2_nap = 1'b1;
         end
         AMC_PD_SLEEP: next_ctrl.sleep = 1'b1;
         default:      next_ctrl.sleep = 1'b0;
      endcase
      next_ctrl.output_clock_invert       = reg_timing[AMC_OUTPUT_CLOCK_INVERT_BIT];
      next_ctrl.output_clock_phase_delay  = reg_timing[2:1];
      next_ctrl.duty_cycle_stabilizer_on  = reg_timing[AMC_DCS_BIT];
      next_ctrl.lvds_drive_current_select = reg_outdrv[6:4];
      next_ctrl.internal_termination_on   = reg_outdrv[AMC_TERM_BIT];
      next_ctrl.lvds_double_current       = reg_outdrv[AMC_TERM_BIT];
      next_ctrl.output_disable            = reg_outdrv[AMC_OUTPUT_DISABLE_BIT];
      next_ctrl.output_format_select      = reg_outdrv[1:0];
      next_ctrl.test_pattern_select       = reg_format[5:3];
      next_ctrl.output_randomizer_on      = reg_format[AMC_OUTPUT_RANDOMIZER_ON_BIT];
      next_ctrl.alternate_bit_polarity    = reg_format[AMC_ABP_BIT];
      next_ctrl.twos_complement_select    = reg_format[AMC_TWOS_BIT]
                                            && !reg_format[AMC_ABP_BIT];
   end

   // Controls registered so every output comes from a flip-flop
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl        <= '0;
         outputs_hiz <= 1'b0;
      end else begin
         ctrl        <= next_ctrl;
         outputs_hiz <= next_ctrl.output_disable;
      end
   end

   // ****************************************************************
   // Test pattern generator, one sample per ref_clk
   // ****************************************************************
   logic phase;

   // Alternation phase flips every sample
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         phase <= 1'b0;
      end else begin
         phase <= ~phase;
      end
   end

   // Pattern or pass-through of the overrange flag and twelve data bits
   // pattern select
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pattern_word   <= 13'h0000;
         pattern_active <= 1'b0;
      end else begin
         pattern_active <= next_ctrl.test_pattern_select != AMC_TP_OFF;
         case (next_ctrl.test_pattern_select)
            AMC_TP_OFF:   pattern_word <= sample_data;
            AMC_TP_ZERO:  pattern_word <= 13'h0000;
            AMC_TP_ONE:   pattern_word <= 13'h1FFF;
            AMC_TP_CHECK: pattern_word <= phase ? AMC_CHECK_B : AMC_CHECK_A;
            AMC_TP_ALT:   pattern_word <= phase ? 13'h1FFF : 13'h0000;
            // Unused codes fall back to live data
            default:      pattern_word <= sample_data;
         endcase
      end
   end

endmodule

/* dv/amc_regs_monitor.sv */
// Checker for the mode register bank outputs
`timescale 1ns/1ps
module amc_regs_monitor
   import amc_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        chip_select_n,
   input wire logic        serial_out_oe_n,
   input wire logic [12:0] sample_data,
   input wire amc_ctrl_t   ctrl,
   input wire logic [12:0] pattern_word,
   input wire logic        pattern_active,
   input wire logic        outputs_hiz
);
   // ************
   // Properties
   // ************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Shorthands; data checks only where no recoding is active
   wire [2:0] tp    = ctrl.test_pattern_select;
   wire       plain = tp == AMC_TP_OFF && !ctrl.output_randomizer_on
                      && !ctrl.twos_complement_select && !ctrl.alternate_bit_polarity;
   AST_NAP_ORDER:
      assert property (ctrl.ch1_nap |-> ctrl.ch2_nap) else $error("channel 1 naps alone");
   AST_DOUBLE_CUR:
      assert property (ctrl.lvds_double_current == ctrl.internal_termination_on)
      else $error("drive doubling differs from termination");
   AST_HIZ:
      assert property ($stable(ctrl.output_disable)[*3] |-> outputs_hiz == ctrl.output_disable)
      else $error("high impedance does not follow disable");
   AST_PAT_ON:
      assert property ($stable(tp)[*2] |-> pattern_active == (tp != 3'h0))
      else $error("pattern flag wrong");
   AST_ZERO:
      assert property ((tp == AMC_TP_ZERO)[*2] |-> pattern_word == 13'h0000)
      else $error("all low pattern wrong");
   AST_ONE:
      assert property ((tp == AMC_TP_ONE)[*2] |-> pattern_word == 13'h1FFF)
      else $error("all high pattern wrong");
   AST_CHECK:
      assert property ((tp == AMC_TP_CHECK)[*3] |-> pattern_word inside {13'h1555, 13'h0AAA}
         && pattern_word != $past(pattern_word)) else $error("checkerboard wrong");
   AST_ALT:
      assert property ((tp == AMC_TP_ALT)[*3] |-> pattern_word inside {13'h0000, 13'h1FFF}
         && pattern_word != $past(pattern_word)) else $error("alternating pattern wrong");
   AST_DATA:
      assert property (plain[*2] |-> pattern_word == $past(sample_data))
      else $error("data not passed");
   AST_ABP:
      assert property (ctrl.alternate_bit_polarity |-> !ctrl.twos_complement_select)
      else $error("twos complement with polarity mode");
   AST_OE_IDLE:
      assert property (chip_select_n[*3] |-> serial_out_oe_n) else $error("output driven idle");
   AST_HOLD:
      assert property (chip_select_n[*8] |-> $stable(ctrl)) else $error("controls moved");
   cover property ((tp == AMC_TP_CHECK)[*3]);
   cover property (!serial_out_oe_n);
   cover property (outputs_hiz);
endmodule
bind amc_regs amc_regs_monitor mon_u (
   .ref_clk, .rst_n, .chip_select_n, .serial_out_oe_n, .sample_data,
   .ctrl, .pattern_word, .pattern_active, .outputs_hiz
);

/* dv/amc_host_model.sv */
// Serial configuration host model for the four-wire port
`timescale 1ns/1ps
module amc_host_model (
   output logic      serial_clk,
   output logic      chip_select_n,
   output logic      serial_in,
   input  wire logic serial_out_o,
   input  wire logic serial_out_oe_n
);
   // ************
   // Host side
   // ************
   // Pull-up on the open-drain return line
   wire sdo = serial_out_oe_n ? 1'b1 : serial_out_o;
   initial begin
      serial_clk = 1'b0;
      chip_select_n = 1'b0;
      serial_in = 1'b0;
      // Edge on chip select clears the link logic once processes run
      #1 chip_select_n = 1'b1;
   end
   // framed transfer
   // Clock runs only inside the frame; bits past 16 are toggling junk
   task automatic xfer(input logic [15:0] w, input int nbits, output logic [7:0] rd);
      rd = 8'h00;
      #7 chip_select_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         serial_in = (i < 16) ? w[15 - i] : ~serial_in;
         #16 serial_clk = 1'b1;
         if (i >= 8 && i < 16) rd = {rd[6:0], sdo};
         #16 serial_clk = 1'b0;
      end
      #16 chip_select_n = 1'b1;
      // Released data line shows the inverse of its last bit
      serial_in = ~serial_in;
      #70;
   endtask
endmodule

/* dv/testbench.sv */
// Self-checking bench for the mode control register bank
`timescale 1ns/1ps
`define CHK(g, e) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      miscompares++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
   end \
end
module testbench
   import amc_pkg::*;
;
   // ************
   // Stimulus
   // ************
   logic        ref_clk;
   logic        rst_n;
   logic [12:0] sample_data;
   wire         serial_clk, chip_select_n, serial_in, serial_out_o, serial_out_oe_n;
   amc_ctrl_t   ctrl;
   logic [12:0] pattern_word;
   logic        pattern_active, outputs_hiz;
   int          miscompares = 0, samples_checked = 0, cycles = 0;
   logic [7:0]  regs [1:4];
   logic [7:0]  rdata;
   localparam logic [7:0] MASK [1:4] = '{8'h03, 8'h0F, 8'h7F, 8'h3F};
   // Rows: write word, then the masked read-back it should give
   // rows keep host rules: no unused codes, stabilizer on with delay
   localparam logic [23:0] ROWS [25] = '{
      24'h01_FC00, 24'h01_0101, 24'h01_0202, 24'h01_0303, 24'h02_0808,
      24'h02_F303, 24'h02_0505, 24'h02_0707, 24'h02_0000, 24'h03_0808,
      24'h03_1414, 24'h03_A121, 24'h03_4242, 24'h03_5050, 24'h03_6060,
      24'h03_7070, 24'h03_0000, 24'h04_0808, 24'h04_1818, 24'h04_2828,
      24'h04_3838, 24'h04_0404, 24'h04_0505, 24'h04_0303, 24'h04_C000};
   amc_regs dut_u (
      .ref_clk, .rst_n, .serial_clk, .chip_select_n, .serial_in, .serial_out_o,
      .serial_out_oe_n, .sample_data, .ctrl, .pattern_word, .pattern_active, .outputs_hiz);
   amc_host_model host_u (.serial_clk, .chip_select_n, .serial_in, .serial_out_o,
      .serial_out_oe_n);
   // Expected controls from the modelled registers
   function automatic amc_ctrl_t model();
      logic [1:0] p;
      p = regs[1][1:0];
      return {p == 2'b10, p inside {2'b01, 2'b10}, p == 2'b11, regs[2][3:0], regs[3][6:3],
              regs[3][3], regs[3][2:0], regs[4][2:0] & {2'b11, ~regs[4][2]}, regs[4][5:3]};
   endfunction
   // Nap bits are left free in sleep, the whole device is down then
   task automatic check_ctrl();
      amc_ctrl_t got;
      got = ctrl;
      if (got.sleep) begin
         got.ch1_nap = 1'b0;
         got.ch2_nap = 1'b0;
      end
      `CHK(got, model())
   endtask
   task automatic complete_run();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Ceiling well above the 3500 cycles the run needs
   always @(posedge ref_clk) begin
      cycles++;
      sample_data <= sample_data + 13'h0135;
      if (cycles == 10000) begin
         miscompares++;
         complete_run();
      end
   end
   initial begin
      // Falling edge after start so the link toggle sees its reset
      rst_n = 1'b1;
      #1 rst_n = 1'b0;
      sample_data = 13'h0000;
      regs = '{default: 8'h00};
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      `CHK({ctrl, outputs_hiz, serial_out_oe_n}, 23'h00_0001)
      foreach (ROWS[i]) begin
         host_u.xfer(ROWS[i][23:8], 16, rdata);
         regs[ROWS[i][18:16]] = ROWS[i][15:8];
         host_u.xfer(ROWS[i][23:8] | 16'h8000, 16, rdata);
         `CHK(rdata & MASK[ROWS[i][18:16]], ROWS[i][7:0])
         check_ctrl();
      end
      host_u.xfer(16'h8500, 16, rdata);
      `CHK(rdata, 8'h00)
      host_u.xfer(16'h0418, 16, rdata);
      regs[4] = 8'h18;
      `CHK({pattern_active, pattern_word}, 14'h3FFF)
      host_u.xfer(16'h10FF, 16, rdata);
      check_ctrl();
      host_u.xfer(16'h0101, 10, rdata);
      check_ctrl();
      host_u.xfer(16'h0102, 20, rdata);
      regs[1] = 8'h02;
      check_ctrl();
      host_u.xfer(16'h0080, 16, rdata);
      regs = '{default: 8'h00};
      check_ctrl();
      host_u.xfer(16'h8100, 16, rdata);
      `CHK(rdata, 8'h00)
      complete_run();
   end
endmodule
